// file: bfs_controller.sv
`timescale 1ns/100ps
module bfs_controller (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Serial bus.
  bfs_if.controller bus,
  // User requests.
  input wire logic selectDevice,
  input wire logic resetReq,
  input wire logic shiftReq,
  input wire logic readDir,
  input wire logic sendValid,
  input wire logic sendCmd,
  input wire logic [1:0] sendBits,
  output logic sendReady,
  // User answers.
  output logic rxValid,
  output logic [1:0] rxBits,
  output logic errorSeen
);
  bfs_pkg::bfs_phase_t phase;
  bfs_pkg::bfs_phase_t next_phase;
  logic [2:0] resetCount;
  logic [1:0] txBits;
  logic txActive;

  always_comb
  begin
    case (phase)
      bfs_pkg::PH_TOKEN: next_phase = bfs_pkg::PH_SLOTA;
      bfs_pkg::PH_SLOTA: next_phase = bfs_pkg::PH_SLOTB;
      bfs_pkg::PH_SLOTB: next_phase = bfs_pkg::PH_GAP;
      default: next_phase = bfs_pkg::PH_TOKEN;
    endcase
  end

  // A token is sent only for a transfer, so idle periods move no bits.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      phase <= bfs_pkg::PH_GAP;
      bus.selIn_n <= 1'b1;
    end
    else
    begin
      phase <= next_phase;
      bus.selIn_n <= next_phase != bfs_pkg::PH_TOKEN || !(sendValid ? (sendCmd || !readDir) : readDir);
    end
  end

  // Device reset is held low for the full count.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      resetCount <= bfs_pkg::RESET_COUNT_INIT;
      bus.devReset_n <= 1'b1;
    end
    else if (resetReq && resetCount == bfs_pkg::RESET_COUNT_INIT)
    begin
      resetCount <= 3'(bfs_pkg::RESET_HOLD);
      bus.devReset_n <= 1'b0;
    end
    else if (resetCount != bfs_pkg::RESET_COUNT_INIT)
    begin
      resetCount <= resetCount - 3'h1;
      bus.devReset_n <= resetCount == 3'h1;
    end
  end

  // Outbound bits are latched at the token and driven in the slots.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      txBits <= 2'h0;
      txActive <= 1'b0;
      sendReady <= 1'b0;
      bus.cmdData <= 1'b0;
      bus.ctrlLineOut <= 1'b0;
      bus.ctrlLineOe <= 1'b0;
      bus.chipSel_n <= 1'b1;
      bus.shiftClk <= 1'b0;
      errorSeen <= 1'b0;
    end
    else
    begin
      bus.chipSel_n <= !selectDevice;
      bus.shiftClk <= shiftReq;
      errorSeen <= !bus.errorFlag_n;
      sendReady <= 1'b0;
      if (phase == bfs_pkg::PH_GAP)
      begin
        txActive <= sendValid && (sendCmd || !readDir);
        sendReady <= sendValid && (sendCmd || !readDir);
        if (sendValid)
        begin
          txBits <= sendBits;
          bus.cmdData <= sendCmd;
        end
        else if (readDir)
        begin
          bus.cmdData <= 1'b0;
        end
      end
      bus.ctrlLineOe <= txActive && (phase == bfs_pkg::PH_TOKEN || phase == bfs_pkg::PH_SLOTA);
      bus.ctrlLineOut <= phase == bfs_pkg::PH_TOKEN ? txBits[0] : txBits[1];
    end
  end

  // Inbound bits are sampled in both slots and handed over together.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rxBits <= 2'h0;
      rxValid <= 1'b0;
    end
    else
    begin
      rxValid <= readDir && !bus.cmdData && phase == bfs_pkg::PH_SLOTB;
      if (phase == bfs_pkg::PH_SLOTA)
      begin
        rxBits[0] <= bus.serialBusLine;
      end
      if (phase == bfs_pkg::PH_SLOTB)
      begin
        rxBits[1] <= bus.serialBusLine;
      end
    end
  end
endmodule

// file: bfs_fifo.sv
`timescale 1ns/100ps
module bfs_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Fill side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic doPush;
  logic doPop;

  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_ff @(posedge ref_clk)
  begin
    if (doPush)
    begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop)
      begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule

// file: bfs_formatter.sv
// What this block does
// - C/D high means command, low means data.
// - A C/D change aborts the running command.
// - Deselected: release data line and token, ignore traffic except C/D aborts; error flag stays driven.
// - Bus reset clears state and disables chip.
// - Controller holds reset low five clocks.
// - Token pulse grants the next two slots.
// - Token output follows token input two clocks.
// - Channel A passes token to B one clock.
// - Data line bidirectional, active high, shared.
// - Support selects change only by decoded commands or bus reset.
// - Error condition pulls open-drain flag low.
// - Shift clock moves write bits, samples reads.
// - Write outputs present FIFO data, active low.
// - Device timing runs on the controller clock.
`timescale 1ns/100ps
module bfs_formatter (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Serial bus.
  bfs_if.device bus,
  // Sense amplifier results.
  input wire logic [1:0] senseBit,
  // Support outputs.
  output logic [1:0] enable_n,
  output logic [1:0] writeData_n,
  output logic errorActive
);
  logic clearAll;
  logic selected;
  logic [1:0] slot;
  logic cmdPrev;
  logic abortCmd;
  logic writeMode;
  logic readMode;
  logic errFlag;
  logic bitA;
  logic [1:0] inLatch;
  logic [1:0] cmdDone;
  logic [1:0] isClearErr;
  logic fifoInReady;
  logic fifoOutValid;
  logic [1:0] fifoOutData;
  logic dataWrite;
  logic pushReq;
  logic shiftWrite;
  logic overflow;
  logic underflow;
  logic [bfs_pkg::CMD_BITS-1:0] cmdWord [bfs_pkg::CHANNELS];

  // Bus reset clears everything and acts as a deselect.
  assign clearAll = reset || !bus.devReset_n;
  assign selected = !bus.chipSel_n && bus.devReset_n;
  assign abortCmd = bus.cmdData != cmdPrev;
  assign dataWrite = selected && !bus.cmdData && writeMode;
  assign pushReq = dataWrite && slot[1];
  assign shiftWrite = selected && bus.shiftClk && writeMode;
  assign overflow = pushReq && !fifoInReady;
  assign underflow = shiftWrite && !fifoOutValid;

  // Token pipeline: channel A slot, then channel B slot together with token out.
  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      slot <= 2'h0;
      bus.selOut_n <= 1'b1;
    end
    else
    begin
      slot[0] <= !bus.selIn_n && selected;
      slot[1] <= slot[0];
      bus.selOut_n <= !slot[0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      cmdPrev <= 1'b0;
    end
    else
    begin
      cmdPrev <= bus.cmdData;
    end
  end

  // Per-channel command shift register and decoder.
  genvar ch;
  generate
    for (ch = 0; ch < bfs_pkg::CHANNELS; ch++)
    begin : gen_chan
      logic [1:0] bitCount;
      always_ff @(posedge ref_clk)
      begin
        if (clearAll)
        begin
          cmdWord[ch] <= '0;
          bitCount <= 2'h0;
          cmdDone[ch] <= 1'b0;
          enable_n[ch] <= 1'b1;
        end
        else
        begin
          cmdDone[ch] <= 1'b0;
          if (abortCmd)
          begin
            bitCount <= 2'h0;
          end
          else if (selected && bus.cmdData && slot[ch])
          begin
            cmdWord[ch] <= {cmdWord[ch][bfs_pkg::CMD_BITS-2:0], bus.serialBusLine};
            bitCount <= bitCount + 2'h1;
            cmdDone[ch] <= bitCount == 2'h3;
          end
          if (cmdDone[ch] && !abortCmd)
          begin
            if (cmdWord[ch] == bfs_pkg::CMD_ENABLE_ON)
            begin
              enable_n[ch] <= 1'b0;
            end
            else if (cmdWord[ch] == bfs_pkg::CMD_ENABLE_OFF)
            begin
              enable_n[ch] <= 1'b1;
            end
          end
        end
      end
      assign isClearErr[ch] = cmdDone[ch] && !abortCmd && cmdWord[ch] == bfs_pkg::CMD_CLEAR_ERROR;
    end
  endgenerate

  // Transfer direction follows channel A commands.
  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      writeMode <= 1'b0;
      readMode <= 1'b0;
    end
    else if (cmdDone[0] && !abortCmd)
    begin
      if (cmdWord[0] == bfs_pkg::CMD_WRITE_MODE)
      begin
        writeMode <= 1'b1;
        readMode <= 1'b0;
      end
      else if (cmdWord[0] == bfs_pkg::CMD_READ_MODE)
      begin
        writeMode <= 1'b0;
        readMode <= 1'b1;
      end
    end
  end

  // Error flag: a new error wins over a clear in the same cycle.
  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      errFlag <= 1'b0;
    end
    else if (overflow || underflow)
    begin
      errFlag <= 1'b1;
    end
    else if (|isClearErr)
    begin
      errFlag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      bus.errOut <= 1'b0;
      bus.errOe <= 1'b0;
      errorActive <= 1'b0;
    end
    else
    begin
      bus.errOut <= 1'b0;
      bus.errOe <= errFlag;
      errorActive <= errFlag;
    end
  end

  // Channel A data bit waits for channel B before the pair is queued.
  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      bitA <= 1'b0;
    end
    else if (dataWrite && slot[0])
    begin
      bitA <= bus.serialBusLine;
    end
  end

  bfs_fifo #(
    .WIDTH(2),
    .DEPTH(bfs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(clearAll),
    .inValid(pushReq),
    .inReady(fifoInReady),
    .inData({bus.serialBusLine, bitA}),
    .outValid(fifoOutValid),
    .outReady(shiftWrite),
    .outData(fifoOutData)
  );

  // Shift clock drives the output latch or samples the sense amps.
  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      writeData_n <= 2'h3;
      inLatch <= 2'h0;
    end
    else if (selected && bus.shiftClk)
    begin
      if (writeMode)
      begin
        writeData_n <= fifoOutValid ? ~fifoOutData : 2'h3;
      end
      else if (readMode)
      begin
        inLatch <= senseBit;
      end
    end
  end

  // Read data goes out only in the two granted slots.
  always_ff @(posedge ref_clk)
  begin
    if (clearAll)
    begin
      bus.devLineOut <= 1'b0;
      bus.devLineOe <= 1'b0;
    end
    else
    begin
      bus.devLineOe <= selected && readMode && !bus.cmdData && (!bus.selIn_n || slot[0]);
      bus.devLineOut <= !bus.selIn_n ? inLatch[0] : inLatch[1];
    end
  end
endmodule

// file: bfs_formatter_test.sv
`timescale 1ns/100ps
module bfs_formatter_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic selectDevice = 1'b0, resetReq = 1'b0, shiftReq = 1'b0, readDir = 1'b0;
  logic sendValid = 1'b0, sendCmd = 1'b0, sendReady, rxValid, errorSeen, errorActive;
  logic [1:0] sendBits = 2'h0, senseBit = 2'h0, rxBits, enable_n, writeData_n;
  int num_errors = 0, checks_done = 0, cycles = 0;
  bfs_if i_bfs_if ();
  bfs_formatter i_bfs_formatter (.ref_clk(ref_clk), .reset(reset), .bus(i_bfs_if.device),
    .senseBit(senseBit), .enable_n(enable_n), .writeData_n(writeData_n), .errorActive(errorActive));
  bfs_controller i_bfs_controller (.ref_clk(ref_clk), .reset(reset), .bus(i_bfs_if.controller),
    .selectDevice(selectDevice), .resetReq(resetReq), .shiftReq(shiftReq), .readDir(readDir),
    .sendValid(sendValid), .sendCmd(sendCmd), .sendBits(sendBits), .sendReady(sendReady),
    .rxValid(rxValid), .rxBits(rxBits), .errorSeen(errorSeen));
  bfs_monitor i_bfs_monitor (.ref_clk(ref_clk), .reset(reset), .chipSel_n(i_bfs_if.chipSel_n),
    .devReset_n(i_bfs_if.devReset_n), .selIn_n(i_bfs_if.selIn_n), .selOut_n(i_bfs_if.selOut_n),
    .ctrlLineOe(i_bfs_if.ctrlLineOe), .devLineOe(i_bfs_if.devLineOe), .errOut(i_bfs_if.errOut),
    .errOe(i_bfs_if.errOe));
  initial forever #10 ref_clk = ~ref_clk;
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check_pair(string what, logic [1:0] exp, logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic send(logic cmd, logic [1:0] bits);
    int n;
    @(negedge ref_clk);
    sendValid = 1'b1;
    sendCmd = cmd;
    sendBits = bits;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (sendReady !== 1'b1 && n < 20);
    check_pair("send ready", 2'h1, {1'b0, sendReady});
    @(negedge ref_clk);
    sendValid = 1'b0;
  endtask
  task automatic command(logic [3:0] codeA, logic [3:0] codeB);
    for (int i = 3; i >= 0; i--)
      send(1'b1, {codeB[i], codeA[i]});
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic shift();
    @(negedge ref_clk);
    shiftReq = 1'b1;
    @(negedge ref_clk);
    shiftReq = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic test_token();
    int n;
    n = 0;
    fork
      send(1'b0, 2'h0);
      begin
        while (i_bfs_if.selIn_n !== 1'b0 && n < 10)
        begin
          @(negedge ref_clk);
          n++;
        end
        check_pair("token in", 2'h0, {1'b0, i_bfs_if.selIn_n});
        @(negedge ref_clk);
        check_pair("token out at one", 2'h1, {1'b0, i_bfs_if.selOut_n});
        @(negedge ref_clk);
        check_pair("token out at two", 2'h0, {1'b0, i_bfs_if.selOut_n});
      end
    join
    $display("test_token done");
  endtask
  task automatic test_enable();
    command(bfs_pkg::CMD_ENABLE_ON, bfs_pkg::CMD_ENABLE_ON);
    check_pair("enable both", 2'h0, enable_n);
    command(bfs_pkg::CMD_ENABLE_OFF, 4'h0);
    check_pair("disable A", 2'h1, enable_n);
    $display("test_enable done");
  endtask
  task automatic test_fifo();
    command(bfs_pkg::CMD_WRITE_MODE, 4'h0);
    for (int i = 0; i <= bfs_pkg::FIFO_DEPTH; i++)
      send(1'b0, i[1:0]);
    repeat (4) @(negedge ref_clk);
    check_pair("overflow error", 2'h1, {1'b0, errorActive});
    check_pair("error flag pin", 2'h0, {1'b0, i_bfs_if.errorFlag_n});
    check_pair("error seen", 2'h1, {1'b0, errorSeen});
    command(bfs_pkg::CMD_CLEAR_ERROR, 4'h0);
    check_pair("error cleared", 2'h0, {1'b0, errorActive});
    for (int i = 0; i < bfs_pkg::FIFO_DEPTH; i++)
    begin
      shift();
      check_pair("write data", ~i[1:0], writeData_n);
    end
    shift();
    check_pair("empty write data", 2'h3, writeData_n);
    check_pair("underflow error", 2'h1, {1'b0, errorActive});
    $display("test_fifo done");
  endtask
  task automatic test_read();
    int n;
    command(bfs_pkg::CMD_READ_MODE, 4'h0);
    readDir = 1'b1;
    for (int v = 0; v < 4; v++)
    begin
      senseBit = v[1:0];
      shift();
      @(negedge ref_clk);
      n = 0;
      while (rxValid !== 1'b1 && n < 16)
      begin
        @(negedge ref_clk);
        n++;
      end
      check_pair("read valid", 2'h1, {1'b0, rxValid});
      check_pair("read bits", v[1:0], rxBits);
    end
    readDir = 1'b0;
    $display("test_read done");
  endtask
  task automatic test_abort();
    command(bfs_pkg::CMD_WRITE_MODE, 4'h0);
    send(1'b1, 2'h0);
    send(1'b1, 2'h0);
    send(1'b0, 2'h0);
    send(1'b1, 2'h0);
    send(1'b1, 2'h3);
    repeat (6) @(negedge ref_clk);
    check_pair("aborted command", 2'h1, enable_n);
    $display("test_abort done");
  endtask
  task automatic test_devreset();
    @(negedge ref_clk);
    resetReq = 1'b1;
    @(negedge ref_clk);
    resetReq = 1'b0;
    repeat (10) @(negedge ref_clk);
    check_pair("reset enables", 2'h3, enable_n);
    check_pair("reset error", 2'h0, {1'b0, errorActive});
    $display("test_devreset done");
  endtask
  task automatic test_deselect();
    selectDevice = 1'b0;
    command(bfs_pkg::CMD_ENABLE_ON, bfs_pkg::CMD_ENABLE_ON);
    check_pair("deselected command", 2'h3, enable_n);
    selectDevice = 1'b1;
    repeat (4) @(negedge ref_clk);
    command(bfs_pkg::CMD_ENABLE_ON, bfs_pkg::CMD_ENABLE_ON);
    check_pair("reselected command", 2'h0, enable_n);
    $display("test_deselect done");
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    selectDevice = 1'b1;
    repeat (4) @(negedge ref_clk);
    test_token();
    test_enable();
    test_fifo();
    test_read();
    test_abort();
    test_devreset();
    test_deselect();
    print_verdict();
  end
endmodule

// file: bfs_if.sv
`timescale 1ns/100ps
interface bfs_if;
  logic cmdData;
  logic chipSel_n;
  logic devReset_n;
  logic selIn_n;
  logic selOut_n;
  logic shiftClk;
  logic ctrlLineOut;
  logic ctrlLineOe;
  logic devLineOut;
  logic devLineOe;
  logic errOut;
  logic errOe;
  logic serialBusLine;
  logic errorFlag_n;

  // The shared line idles high when nobody drives it.
  assign serialBusLine = ctrlLineOe ? ctrlLineOut : (devLineOe ? devLineOut : 1'b1);
  assign errorFlag_n = errOe ? errOut : 1'b1;

  modport device (
    input cmdData, chipSel_n, devReset_n, selIn_n, shiftClk, serialBusLine,
    output selOut_n, devLineOut, devLineOe, errOut, errOe
  );
  modport controller (
    input selOut_n, serialBusLine, errorFlag_n,
    output cmdData, chipSel_n, devReset_n, selIn_n, shiftClk, ctrlLineOut, ctrlLineOe
  );
endinterface

// file: bfs_monitor.sv
`timescale 1ns/100ps
module bfs_monitor (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Serial bus.
  input wire logic chipSel_n,
  input wire logic devReset_n,
  input wire logic selIn_n,
  input wire logic selOut_n,
  input wire logic ctrlLineOe,
  input wire logic devLineOe,
  input wire logic errOut,
  input wire logic errOe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  a_token_two_late: assert property (
    (!selIn_n && !chipSel_n && devReset_n) ##1 (!chipSel_n && devReset_n)[*2] |-> !selOut_n)
    else $error("token output late or missing");
  a_token_out_cause: assert property (
    !selOut_n |-> $past(selIn_n, 2) == 1'b0)
    else $error("token output without token input");
  a_token_one_cycle: assert property (
    !selOut_n |=> selOut_n)
    else $error("token output longer than one cycle");
  a_desel_float: assert property (
    (chipSel_n || !devReset_n) |=> !devLineOe)
    else $error("device drives line while disabled");
  a_reset_clears: assert property (
    !devReset_n |=> !errOe && selOut_n)
    else $error("bus reset left state behind");
  a_drive_in_slot: assert property (
    devLineOe |-> ($past(selIn_n) == 1'b0 || $past(selIn_n, 2) == 1'b0))
    else $error("device drives outside its slots");
  a_line_no_clash: assert property (
    !(devLineOe && ctrlLineOe))
    else $error("both ends drive the line");
  a_reset_five: assert property (
    $fell(devReset_n) |-> !devReset_n[*5] ##1 devReset_n)
    else $error("bus reset not five cycles");
  a_err_drain_low: assert property (
    errOe |-> !errOut)
    else $error("error flag driven high");
endmodule

// file: bfs_pkg.sv
package bfs_pkg;
  localparam int CHANNELS = 2;
  localparam int CMD_BITS = 4;
  localparam int FIFO_DEPTH = 32;
  localparam int RESET_HOLD = 5;
  localparam logic [CMD_BITS-1:0] CMD_ENABLE_ON = 4'h1;
  localparam logic [CMD_BITS-1:0] CMD_ENABLE_OFF = 4'h2;
  localparam logic [CMD_BITS-1:0] CMD_CLEAR_ERROR = 4'h3;
  localparam logic [CMD_BITS-1:0] CMD_WRITE_MODE = 4'h4;
  localparam logic [CMD_BITS-1:0] CMD_READ_MODE = 4'h5;
  localparam logic [2:0] RESET_COUNT_INIT = 3'h0;
  typedef enum logic [3:0] {
    PH_TOKEN = 4'h1,
    PH_SLOTA = 4'h2,
    PH_SLOTB = 4'h4,
    PH_GAP = 4'h8
  } bfs_phase_t;
endpackage
